// *** src/fxd_core.sv ***
`timescale 1ns/10ps

// Overview of operation
// - Circular qualifier only beside indirect memory ops
// - Qualifier forces circular wrap on all pointers
// - Delay copies word to next higher address
// - Delay destination address never wraps circularly
// - Delay to I/O space raises bus error
// - Exponent equals redundant sign bits minus eight
// - Count aligns value on signed 32 bits
// - Exponent keeps source; zero accumulator gives zero
// - One encoding; sub bit picks symmetric/antisymmetric
// - Multiply acc bits 32..16 by coefficient, accumulate
// - Fractional shift; multiply saturation per control bit
// - Accumulate overflow sets flag, saturates per mode
// - Symmetric: sum of shifted memory words
// - Antisymmetric: difference of shifted memory words
// - Forty-bit ALU, sign extension, carry, saturation
// - Subtraction carry is inverted borrow
// - Legacy mode: antisymmetric skips overflow handling
// - External coefficient address gives bus error
module fxd_core #(
	parameter int MEM_AW = 8   // Data memory address bits
) (
	input  wire logic        pclk,     // APB clock
	input  wire logic        presetn,  // Async reset, active low
	input  wire logic        psel,     // APB select
	input  wire logic        penable,  // APB enable
	input  wire logic        pwrite,   // APB direction
	input  wire logic [7:0]  paddr,    // APB byte address
	input  wire logic [31:0] pwdata,   // APB write data
	output logic      [31:0] prdata,   // APB read data
	output logic             pready,   // APB ready
	output logic             pslverr,  // APB error
	output logic             irq       // Level interrupt
);

	// Pointers are 16 bits, which bounds the memory
	if (MEM_AW < 2 || MEM_AW > 16) begin : g_bad_aw
		$error("fxd_core: MEM_AW must be 2..16");
	end

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Zero input gives zero, not minus the bias
	function automatic logic [15:0] exp_of(input logic [39:0] a);
		logic [5:0] n;
		logic       stop;
		logic [6:0] r;
		n    = 6'h00;
		stop = 1'b0;
		for (int i = 38; i >= 0; i--) begin
			if (!stop && a[i] == a[39]) begin
				n = n + 6'h01;
			end else begin
				stop = 1'b1;
			end
		end
		r = {1'b0, n} - fxd_pkg::EXP_BIAS;
		if (a == 40'h00_0000_0000) begin
			return 16'h0000;
		end
		return {{9{r[6]}}, r};
	endfunction : exp_of

	// Width of the check follows wide mode
	function automatic logic ovf_of(input logic [40:0] s, input logic m40);
		if (m40) begin
			return s[40] ^ s[39];
		end
		return !((&s[40:31]) || !(|s[40:31]));
	endfunction : ovf_of

	// Clamps only when saturation is on
	function automatic logic [39:0] sat_of(input logic [40:0] s, input logic m40,
	                                       input logic saturation_mode_bit, input logic ovf);
		if (!(ovf && saturation_mode_bit)) begin
			return s[39:0];
		end
		if (m40) begin
			return s[40] ? fxd_pkg::SAT40_NEG : fxd_pkg::SAT40_POS;
		end
		return s[40] ? fxd_pkg::SAT32_NEG : fxd_pkg::SAT32_POS;
	endfunction : sat_of

	// Size zero keeps the pointer linear
	function automatic logic [15:0] step_ptr(input logic [15:0] p, input logic circ,
	                                         input logic [15:0] start, input logic [15:0] size);
		logic [15:0] n;
		n = p + 16'h0001;
		if (circ && size != 16'h0000 && n == start + size) begin
			n = start;
		end
		return n;
	endfunction : step_ptr

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [fxd_pkg::MODE_W-1:0] mode_ff;
	fxd_pkg::fxd_cmd_t          cmd_ff;
	logic                       go_ff;
	logic                       carry_ff;
	logic [fxd_pkg::IRQ_W-1:0]  istat_ff;
	logic [fxd_pkg::IRQ_W-1:0]  imask_ff;
	logic [31:0]                buf_ff;
	logic [15:0]                maddr_ff;

	logic [39:0]                acc_ff [fxd_pkg::NUM_ACC];
	logic [15:0]                tmp_ff [fxd_pkg::NUM_ACC];
	logic [15:0]                ptr_ff [fxd_pkg::NUM_PTR];
	logic [15:0]                mem    [2**MEM_AW];

	// Bus-side output flops
	logic [31:0]                prdata_ff;
	logic                       pready_ff;
	logic                       pslverr_ff;
	logic                       irq_ff;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire logic [4:0] idx      = paddr[6:2];
	wire logic       mapped   = paddr[1:0] == 2'b00 && paddr <= fxd_pkg::REG_LAST;

	// Windows of the register arrays
	wire logic       acc_sel  = paddr >= fxd_pkg::REG_ACC0 && paddr < fxd_pkg::REG_TMP0;
	wire logic       tmp_sel  = paddr >= fxd_pkg::REG_TMP0 && paddr < fxd_pkg::REG_PTR0;
	wire logic       ptr_sel  = paddr >= fxd_pkg::REG_PTR0 && paddr <= fxd_pkg::REG_LAST;
	wire logic [1:0] acc_k    = idx[2:1];
	wire logic [1:0] tmp_k    = idx[1:0];
	wire logic [2:0] ptr_k    = 3'(idx - 5'd20);

	wire logic       wr_en    = psel && penable && pready_ff && pwrite && mapped;
	wire logic [MEM_AW-1:0] maddr_w = maddr_ff[MEM_AW-1:0];

	// Unmapped offsets read zero
	logic [31:0] rd_data;
	always_comb begin
		rd_data = 32'h0000_0000;
		if (acc_sel) begin
			rd_data = idx[0] ? {24'h00_0000, acc_ff[acc_k][39:32]} : acc_ff[acc_k][31:0];
		end else if (tmp_sel) begin
			rd_data = {16'h0000, tmp_ff[tmp_k]};
		end else if (ptr_sel) begin
			rd_data = {16'h0000, ptr_ff[ptr_k]};
		end else begin
			case (paddr)
				fxd_pkg::REG_MODE:  rd_data = {17'h0_0000, mode_ff};
				fxd_pkg::REG_CMD:   rd_data = cmd_ff;
				fxd_pkg::REG_STATE: rd_data = {30'h0000_0000, carry_ff, go_ff};
				fxd_pkg::REG_ISTAT: rd_data = {25'h000_0000, istat_ff};
				fxd_pkg::REG_IMASK: rd_data = {25'h000_0000, imask_ff};
				fxd_pkg::REG_BUF:   rd_data = buf_ff;
				fxd_pkg::REG_MADDR: rd_data = {16'h0000, maddr_ff};
				fxd_pkg::REG_MDATA: rd_data = {16'h0000, mem[maddr_w]};
				default:            rd_data = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Operation decode (execute stage, one cycle after the CMD write)
	// ----------------------------------------------------------------
	wire logic       op_fir   = cmd_ff.opcode == fxd_pkg::OPC_FIR;
	wire logic       op_dly   = cmd_ff.opcode == fxd_pkg::OPC_DELAY;
	wire logic       op_exp   = cmd_ff.opcode == fxd_pkg::OPC_EXP;
	wire logic       qual_on  = cmd_ff.qual == fxd_pkg::OPC_CIRC;

	// Qualifier needs a memory operand
	wire logic       qual_bad = cmd_ff.qual != fxd_pkg::OPC_NONE && (!qual_on || op_exp);
	wire logic       illegal  = qual_bad || !(op_fir || op_dly || op_exp);
	// Refused ops change no state except their ISTAT flag
	wire logic       berr     = (op_dly && cmd_ff.io_space)
	                         || (op_fir && cmd_ff.coef_ext);
	wire logic       run      = go_ff && !illegal && !berr;

	// Arithmetic mode bits
	wire logic       m40      = mode_ff[fxd_pkg::MODE_M40];
	wire logic       saturation_mode_bit     = mode_ff[fxd_pkg::MODE_SATURATION_MODE_BIT];
	wire logic       sign_extension_bit     = mode_ff[fxd_pkg::MODE_SIGN_EXTENSION_BIT];
	wire logic [15:0] buf_st  = buf_ff[15:0];
	wire logic [15:0] buf_sz  = buf_ff[31:16];

	// Pointers and operand words
	wire logic [15:0] px_val  = ptr_ff[cmd_ff.px];
	wire logic [15:0] py_val  = ptr_ff[cmd_ff.py];
	wire logic [15:0] cp_val  = ptr_ff[fxd_pkg::CDP_IDX];
	wire logic [15:0] x_word  = mem[px_val[MEM_AW-1:0]];
	wire logic [15:0] y_word  = mem[py_val[MEM_AW-1:0]];
	wire logic [15:0] c_word  = mem[cp_val[MEM_AW-1:0]];

	// Delay target never wraps
	wire logic [MEM_AW-1:0] dly_dst = MEM_AW'(px_val + 16'h0001);

	wire logic        circ_x  = mode_ff[cmd_ff.px] || qual_on;
	wire logic        circ_y  = mode_ff[cmd_ff.py] || qual_on;
	wire logic        circ_c  = mode_ff[fxd_pkg::MODE_CDP_CIRC] || qual_on;
	wire logic [15:0] px_nxt  = step_ptr(px_val, circ_x, buf_st, buf_sz);
	wire logic [15:0] py_nxt  = step_ptr(py_val, circ_y, buf_st, buf_sz);
	wire logic [15:0] cp_nxt  = step_ptr(cp_val, circ_c, buf_st, buf_sz);

	// ----------------------------------------------------------------
	// Multiply-accumulate half
	// ----------------------------------------------------------------
	// Both halves read acc_ff before the edge that writes either result
	wire logic [39:0] acx_old = acc_ff[cmd_ff.first_accumulator];
	wire logic [39:0] acy_old = acc_ff[cmd_ff.second_accumulator];
	wire logic signed [16:0] mul_a = $signed(acx_old[32:16]);
	wire logic signed [16:0] mul_c = $signed({c_word[15], c_word});
	wire logic signed [33:0] prod  = mul_a * mul_c;
	wire logic signed [34:0] prod_s = mode_ff[fxd_pkg::MODE_FRACTIONAL_MODE_BIT] ? (35'(prod) <<< 1) : 35'(prod);
	wire logic        mul_ovf = mode_ff[fxd_pkg::MODE_MULTIPLY_SATURATE_BIT]
	                         && (prod_s > 35'sh7FFF_FFFF || prod_s < -35'sh8000_0000);
	// Saturate the product before extension
	wire logic [31:0] prod32  = !mul_ovf ? prod_s[31:0]
	                         : (prod_s[34] ? 32'h8000_0000 : 32'h7FFF_FFFF);
	wire logic [39:0] prod40  = {{8{prod32[31]}}, prod32};

	wire logic [40:0] mac_sum = {acy_old[39], acy_old} + {prod40[39], prod40};
	wire logic        mac_ovf = ovf_of(mac_sum, m40);
	wire logic [39:0] mac_res = sat_of(mac_sum, m40, saturation_mode_bit, mac_ovf);

	// ----------------------------------------------------------------
	// Add / subtract half
	// ----------------------------------------------------------------
	wire logic [39:0] x40     = {sign_extension_bit ? {8{x_word[15]}} : 8'h00, x_word, 16'h0000};
	wire logic [39:0] y40     = {sign_extension_bit ? {8{y_word[15]}} : 8'h00, y_word, 16'h0000};
	wire logic [39:0] y_opd   = cmd_ff.sub ? ~y40 : y40;
	wire logic        cin     = cmd_ff.sub;

	// Operands sit in bits 31..16
	wire logic [40:0] alu_sum = {x40[39], x40} + {y_opd[39], y_opd} + {40'h00_0000_0000, cin};
	wire logic [40:0] cy40    = {1'b0, x40} + {1'b0, y_opd} + {40'h00_0000_0000, cin};
	wire logic [32:0] cy32    = {1'b0, x40[31:0]} + {1'b0, y_opd[31:0]} + {32'h0000_0000, cin};
	// Subtract adds the inverted operand plus one, so carry out is already !borrow
	wire logic        alu_cy  = m40 ? cy40[40] : cy32[32];
	wire logic        no_chk  = cmd_ff.sub && mode_ff[fxd_pkg::MODE_LEGACY_COMPAT_BIT];
	wire logic        alu_ovf = ovf_of(alu_sum, m40) && !no_chk;
	wire logic [39:0] alu_res = sat_of(alu_sum, m40, saturation_mode_bit, alu_ovf);

	// ----------------------------------------------------------------
	// Events
	// ----------------------------------------------------------------
	logic [fxd_pkg::IRQ_W-1:0] ev;
	always_comb begin
		ev = '0;
		if (run && op_fir) begin
			ev[fxd_pkg::IRQ_OVF_LSB + cmd_ff.second_accumulator] = mac_ovf;
			ev[fxd_pkg::IRQ_OVF_LSB + cmd_ff.first_accumulator] = ev[cmd_ff.first_accumulator] | alu_ovf;
		end
		ev[fxd_pkg::IRQ_BERR]    = go_ff && !illegal && berr;
		ev[fxd_pkg::IRQ_ILLEGAL] = go_ff && illegal;
		ev[fxd_pkg::IRQ_DONE]    = run;
	end

	// Set beats a same-cycle clear
	wire logic [fxd_pkg::IRQ_W-1:0] w1c = (wr_en && paddr == fxd_pkg::REG_ISTAT)
	                                     ? pwdata[fxd_pkg::IRQ_W-1:0] : '0;
	wire logic [fxd_pkg::IRQ_W-1:0] nxt_istat = (istat_ff & ~w1c) | ev;

	// ----------------------------------------------------------------
	// APB slave and control registers
	// ----------------------------------------------------------------
	// Zero wait states; never stalls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
			irq_ff     <= 1'b0;
			istat_ff   <= '0;
		end else begin
			pready_ff  <= psel && !penable;
			pslverr_ff <= psel && !penable && !mapped;
			prdata_ff  <= (psel && !penable && !pwrite && mapped) ? rd_data : 32'h0000_0000;
			istat_ff   <= nxt_istat;
			irq_ff     <= |(nxt_istat & imask_ff);
		end
	end

	// go pulses for exactly one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff  <= fxd_pkg::MODE_RST;
			imask_ff <= '0;
			buf_ff   <= 32'h0000_0000;
			maddr_ff <= 16'h0000;
			cmd_ff   <= '0;
			go_ff    <= 1'b0;
		end else begin
			go_ff <= wr_en && paddr == fxd_pkg::REG_CMD;
			if (wr_en && paddr == fxd_pkg::REG_CMD) begin
				cmd_ff <= pwdata;
			end
			if (wr_en && paddr == fxd_pkg::REG_MODE) begin
				mode_ff <= pwdata[fxd_pkg::MODE_W-1:0];
			end
			if (wr_en && paddr == fxd_pkg::REG_IMASK) begin
				imask_ff <= pwdata[fxd_pkg::IRQ_W-1:0];
			end
			if (wr_en && paddr == fxd_pkg::REG_BUF) begin
				buf_ff <= pwdata;
			end
			if (wr_en && paddr == fxd_pkg::REG_MADDR) begin
				maddr_ff <= pwdata[15:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Datapath registers; the executing operation wins over APB writes
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carry_ff <= 1'b0;
			for (int i = 0; i < fxd_pkg::NUM_ACC; i++) begin
				acc_ff[i] <= 40'h00_0000_0000;
				tmp_ff[i] <= 16'h0000;
			end
			for (int i = 0; i < fxd_pkg::NUM_PTR; i++) begin
				ptr_ff[i] <= 16'h0000;
			end
		end else begin
			if (wr_en && acc_sel && idx[0]) begin
				acc_ff[acc_k][39:32] <= pwdata[7:0];
			end
			if (wr_en && acc_sel && !idx[0]) begin
				acc_ff[acc_k][31:0] <= pwdata;
			end
			if (wr_en && tmp_sel) begin
				tmp_ff[tmp_k] <= pwdata[15:0];
			end
			if (wr_en && ptr_sel) begin
				ptr_ff[ptr_k] <= pwdata[15:0];
			end

			// Operation results override APB loads
			if (run && op_exp) begin
				tmp_ff[cmd_ff.tdst] <= exp_of(acx_old);
			end
			if (run && op_dly) begin
				ptr_ff[cmd_ff.px] <= px_nxt;
			end
			if (run && op_fir) begin
				ptr_ff[cmd_ff.px]        <= px_nxt;
				ptr_ff[cmd_ff.py]        <= py_nxt;
				ptr_ff[fxd_pkg::CDP_IDX] <= cp_nxt;
				acc_ff[cmd_ff.second_accumulator]       <= mac_res;
				acc_ff[cmd_ff.first_accumulator]       <= alu_res;
				carry_ff                 <= alu_cy;
			end
		end
	end

	// Data memory has no reset; software loads it through MADDR/MDATA
	// Delay wins over an MDATA write in one cycle
	always_ff @(posedge pclk) begin
		if (run && op_dly) begin
			mem[dly_dst] <= mem[px_val[MEM_AW-1:0]];
		end else if (wr_en && paddr == fxd_pkg::REG_MDATA) begin
			mem[maddr_w] <= pwdata[15:0];
		end
	end

	// Ports come straight from flops
	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq     = irq_ff;

endmodule : fxd_core

// *** src/fxd_pkg.sv ***
package fxd_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets (APB, 32-bit aligned words)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_MODE   = 8'h00;
	localparam logic [7:0] REG_CMD    = 8'h04;
	localparam logic [7:0] REG_STATE  = 8'h08;
	localparam logic [7:0] REG_ISTAT  = 8'h0C;
	localparam logic [7:0] REG_IMASK  = 8'h10;
	localparam logic [7:0] REG_BUF    = 8'h14;
	localparam logic [7:0] REG_MADDR  = 8'h18;
	localparam logic [7:0] REG_MDATA  = 8'h1C;
	localparam logic [7:0] REG_ACC0   = 8'h20;
	localparam logic [7:0] REG_TMP0   = 8'h40;
	localparam logic [7:0] REG_PTR0   = 8'h50;
	localparam logic [7:0] REG_LAST   = 8'h60;

	// ----------------------------------------------------------------
	// Mode register fields (status_word_two and arithmetic modes)
	// ----------------------------------------------------------------
	localparam int MODE_CIRC_LSB = 0;
	localparam int MODE_CIRC_W   = 9;
	localparam int MODE_CDP_CIRC = 8;
	localparam int MODE_FRACTIONAL_MODE_BIT     = 9;
	localparam int MODE_MULTIPLY_SATURATE_BIT     = 10;
	localparam int MODE_M40      = 11;
	localparam int MODE_SATURATION_MODE_BIT     = 12;
	localparam int MODE_SIGN_EXTENSION_BIT     = 13;
	localparam int MODE_LEGACY_COMPAT_BIT    = 14;
	localparam int MODE_W        = 15;
	localparam logic [14:0] MODE_RST = 15'h0000;

	// ----------------------------------------------------------------
	// Interrupt status / mask layout
	// ----------------------------------------------------------------
	localparam int IRQ_OVF_LSB = 0;
	localparam int IRQ_BERR    = 4;
	localparam int IRQ_ILLEGAL = 5;
	localparam int IRQ_DONE    = 6;
	localparam int IRQ_W       = 7;

	// ----------------------------------------------------------------
	// Operation codes
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_CIRC  = 8'h9D;
	localparam logic [7:0] OPC_DELAY = 8'hB6;
	localparam logic [7:0] OPC_EXP   = 8'h10;
	localparam logic [7:0] OPC_FIR   = 8'h85;
	localparam logic [7:0] OPC_NONE  = 8'h00;

	// ----------------------------------------------------------------
	// Arithmetic constants
	// ----------------------------------------------------------------
	localparam logic [39:0] SAT40_POS = 40'h7F_FFFF_FFFF;
	localparam logic [39:0] SAT40_NEG = 40'h80_0000_0000;
	localparam logic [39:0] SAT32_POS = 40'h00_7FFF_FFFF;
	localparam logic [39:0] SAT32_NEG = 40'hFF_8000_0000;
	localparam logic [6:0]  EXP_BIAS  = 7'h08;
	localparam int NUM_ACC = 4;
	localparam int NUM_PTR = 5;
	localparam int CDP_IDX = 4;

	// Command word written to REG_CMD
	typedef struct packed {
		logic [7:0] qual;      // OPC_CIRC when the qualifier is paired
		logic       io_space;  // Operand addressed in I/O space
		logic       coef_ext;  // Coefficient mapped on external memory
		logic [1:0] tdst;      // Exponent destination temp
		logic [1:0] py;        // Second memory operand pointer
		logic [1:0] px;        // First memory operand pointer
		logic [1:0] second_accumulator;       // Second accumulator
		logic [1:0] first_accumulator;       // First accumulator
		logic       sub;       // Filter: 0 symmetric, 1 antisymmetric
		logic [2:0] rsvd;
		logic [7:0] opcode;
	} fxd_cmd_t;

endpackage : fxd_pkg

// *** verif/fxd_core_props.sv ***
`timescale 1ns/10ps
module fxd_core_props (
	input wire logic        pclk,    // Clock
	input wire logic        presetn, // Reset, active low
	input wire logic        psel,    // Select
	input wire logic        penable, // Enable
	input wire logic        pwrite,  // Direction
	input wire logic [7:0]  paddr,   // Address
	input wire logic [31:0] pwdata,  // Write data
	input wire logic [31:0] prdata,  // Read data
	input wire logic        pready,  // Ready
	input wire logic        pslverr, // Error
	input wire logic        irq      // Interrupt
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wr_done = psel && penable && pready && pwrite;
	chk_ready_first: assert property (psel && penable && !$past(penable) |-> pready)
		else $error("ready missing in first access cycle");
	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_err_unmapped: assert property (pready && (paddr > fxd_pkg::REG_LAST || paddr[1:0] != 2'h0) |-> pslverr)
		else $error("unmapped access not refused");
	chk_ok_mapped: assert property (pready && paddr <= fxd_pkg::REG_LAST && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access refused");
	chk_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0000_0000)
		else $error("read data outside read answer");
	chk_irq_rise: assert property ($rose(irq) |-> $past(wr_done, 2) || $past(wr_done, 3))
		else $error("interrupt rose without a cause");
	chk_irq_fall: assert property ($fell(irq) |-> $past(wr_done) || $past(wr_done, 2))
		else $error("interrupt fell without a write");
	chk_err_rdata: assert property (pslverr |-> prdata == 32'h0000_0000)
		else $error("refused read returned data");
	cov_refused: cover property (pready && pslverr);
	cov_irq: cover property ($rose(irq));
	cov_read: cover property (pready && !pwrite);
endmodule : fxd_core_props

bind fxd_core fxd_core_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// *** verif/fxd_apb_host.sv ***
`timescale 1ns/10ps
module fxd_apb_host (
	input  wire logic        pclk,    // Clock
	input  wire logic        pready,  // Ready
	input  wire logic [31:0] prdata,  // Read data
	input  wire logic        pslverr, // Error
	output logic             psel,    // Select
	output logic             penable, // Enable
	output logic             pwrite,  // Direction
	output logic [7:0]       paddr,   // Address
	output logic [31:0]      pwdata   // Write data
);
	int tmo = 0;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) tmo++;
		q = prdata;
		e = pslverr;
		// Released lines show the inverse so stale values cannot pass
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : fxd_apb_host

// *** verif/fxd_core_bench.sv ***
`timescale 1ns/10ps
module fxd_core_bench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e, cy;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q, d;
	logic [15:0] x, y, cf, ra;
	logic [39:0] v, ay;
	longint      xa, ya, r, mk;
	int          err_count = 0;
	int          n_compared = 0;
	int          seed = 63257;
	fxd_pkg::fxd_cmd_t c;

	fxd_core #(.MEM_AW(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
	fxd_apb_host i_host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic report_and_stop();
		if (err_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string s, input logic [39:0] got, input logic [39:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", s, exp, got);
		end
	endtask : chk
	task automatic io(input logic w, input logic [7:0] a, input logic [31:0] wd);
		i_host.xfer(w, a, wd, q, e);
		if (i_host.tmo != 0) begin
			err_count++;
			report_and_stop();
		end
	endtask : io
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string s);
		io(1'b0, a, 32'h0000_0000);
		chk(s, 40'(q), 40'(exp));
	endtask : rd
	task automatic mw(input logic [7:0] a, input logic [15:0] wd);
		io(1'b1, fxd_pkg::REG_MADDR, 32'(a));
		io(1'b1, fxd_pkg::REG_MDATA, 32'(wd));
	endtask : mw
	task automatic mr(input logic [7:0] a, input logic [15:0] exp, input string s);
		io(1'b1, fxd_pkg::REG_MADDR, 32'(a));
		rd(fxd_pkg::REG_MDATA, 32'(exp), s);
	endtask : mr
	task automatic wacc(input int k, input logic [39:0] wv);
		io(1'b1, fxd_pkg::REG_ACC0 + 8'(8 * k), wv[31:0]);
		io(1'b1, fxd_pkg::REG_ACC0 + 8'(8 * k + 4), 32'(wv[39:32]));
	endtask : wacc
	task automatic racc(input int k, input logic [39:0] exp, input string s);
		rd(fxd_pkg::REG_ACC0 + 8'(8 * k), exp[31:0], s);
		rd(fxd_pkg::REG_ACC0 + 8'(8 * k + 4), 32'(exp[39:32]), s);
	endtask : racc
	task automatic clr(input logic [31:0] exp);
		rd(fxd_pkg::REG_ISTAT, exp, "istat");
		io(1'b1, fxd_pkg::REG_ISTAT, 32'h0000_007F);
	endtask : clr
	task automatic fir(input logic sub, input int ac);
		mw(8'h10, x);
		mw(8'h11, y);
		mw(8'h12, cf);
		io(1'b1, fxd_pkg::REG_PTR0, 32'h0000_0010);
		io(1'b1, fxd_pkg::REG_PTR0 + 8'h04, 32'h0000_0011);
		io(1'b1, fxd_pkg::REG_LAST, 32'h0000_0012);
		wacc(0, v);
		wacc(ac, ay);
		c = '0;
		c.opcode = fxd_pkg::OPC_FIR;
		c.sub = sub;
		c.second_accumulator = 2'(ac);
		c.py = 2'h1;
		io(1'b1, fxd_pkg::REG_CMD, c);
	endtask : fir
	function automatic logic [15:0] expo(input logic [39:0] a);
		int n = 0;
		if (a == 40'h00_0000_0000) return 16'h0000;
		for (int i = 38; i >= 0 && a[i] == a[39]; i--) n++;
		return 16'(n - 8);
	endfunction : expo

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(fxd_pkg::REG_MODE, 32'h0000_0000, "mode reset");
		io(1'b0, 8'h7C, 32'h0000_0000);
		chk("unmapped", {7'h00, e, q}, 40'h01_0000_0000);
		io(1'b1, 8'h02, 32'h0000_0001);
		chk("misaligned", 40'(e), 40'h01);
		io(1'b1, fxd_pkg::REG_IMASK, 32'h0000_007F);
		d = $random(seed);
		mw(8'h20, d[15:0]);
		mw(8'h21, ~d[15:0]);
		io(1'b1, fxd_pkg::REG_PTR0, 32'h0000_0020);
		c = '0;
		c.opcode = fxd_pkg::OPC_DELAY;
		io(1'b1, fxd_pkg::REG_CMD, c);
		mr(8'h21, d[15:0], "delay dst");
		mr(8'h20, d[15:0], "delay src");
		rd(fxd_pkg::REG_PTR0, 32'h0000_0021, "delay ptr");
		chk("irq", 40'(irq), 40'h01);
		clr(32'h0000_0040);
		io(1'b1, fxd_pkg::REG_BUF, 32'h0002_0020);
		c.qual = fxd_pkg::OPC_CIRC;
		io(1'b1, fxd_pkg::REG_CMD, c);
		mr(8'h22, d[15:0], "no dst wrap");
		rd(fxd_pkg::REG_PTR0, 32'h0000_0020, "forced wrap");
		clr(32'h0000_0040);
		c.qual = fxd_pkg::OPC_NONE;
		c.io_space = 1'b1;
		io(1'b1, fxd_pkg::REG_CMD, c);
		rd(fxd_pkg::REG_PTR0, 32'h0000_0020, "io ptr");
		clr(32'h0000_0010);
		c = '0;
		c.qual = 8'h55;
		c.opcode = fxd_pkg::OPC_DELAY;
		io(1'b1, fxd_pkg::REG_CMD, c);
		clr(32'h0000_0020);
		c.qual = fxd_pkg::OPC_CIRC;
		c.opcode = fxd_pkg::OPC_EXP;
		io(1'b1, fxd_pkg::REG_CMD, c);
		clr(32'h0000_0020);
		for (int i = 0; i < 8; i++) begin
			v = 40'({$random(seed), $random(seed)});
			v = 40'($signed(v) >>> ($unsigned($random(seed)) % 40));
			if (i == 0) v = 40'h00_0000_0000;
			if (i == 1) v = 40'hFF_FFFF_FFCB;
			wacc(i % 4, v);
			c = '0;
			c.opcode = fxd_pkg::OPC_EXP;
			c.first_accumulator = 2'(i);
			c.tdst = 2'(i + 1);
			io(1'b1, fxd_pkg::REG_CMD, c);
			io(1'b0, fxd_pkg::REG_TMP0 + 8'(4 * ((i + 1) % 4)), 32'h0000_0000);
			chk("exponent", 40'(q[15:0]), 40'(expo(v)));
			racc(i % 4, v, "exp source");
			clr(32'h0000_0040);
		end
		io(1'b1, fxd_pkg::REG_MODE, 32'h0000_2800);
		mk = 64'h00FF_FFFF_FFFF;
		for (int i = 0; i < 8; i++) begin
			{x, y} = $random(seed);
			{cf, ra} = $random(seed);
			d = $random(seed);
			v = 40'((longint'($signed(ra)) <<< 16) + (d & 32'h0000_FFFF));
			ay = 40'(longint'($signed(d)));
			fir(i[0], 1 + i % 3);
			xa = longint'($signed(x)) <<< 16;
			ya = longint'($signed(y)) <<< 16;
			r = i[0] ? xa - ya : xa + ya;
			cy = i[0] ? ((xa & mk) >= (ya & mk)) : 1'(((xa & mk) + (ya & mk)) >>> 40);
			racc(0, 40'(r), "fir add sub");
			racc(1 + i % 3, 40'(longint'($signed(d)) + longint'($signed(ra)) * longint'($signed(cf))), "fir mac");
			io(1'b0, fxd_pkg::REG_STATE, 32'h0000_0000);
			chk("carry", 40'(q[1]), 40'(cy));
			clr(32'h0000_0040);
		end
		for (int i = 0; i < 2; i++) begin
			io(1'b1, fxd_pkg::REG_MODE, i ? 32'h0000_0600 : 32'h0000_0200);
			{x, y, cf, ay} = {32'h0000_0000, i ? 16'h8000 : 16'h0005, 40'h00_0000_0000};
			v = i ? 40'h01_0000_0000 : 40'h00_0003_0000;
			fir(1'b0, 2);
			racc(2, i ? 40'h00_7FFF_FFFF : 40'h00_0000_001E, "fractional_mode_bit multiply_saturate_bit");
			clr(32'h0000_0040);
		end
		io(1'b1, fxd_pkg::REG_MODE, 32'h0000_3000);
		{x, y, cf} = {16'h4000, 16'h4000, 16'h0001};
		v = 40'h00_0001_0000;
		ay = 40'h00_7FFF_FFFF;
		fir(1'b0, 1);
		racc(0, fxd_pkg::SAT32_POS, "sat add");
		racc(1, fxd_pkg::SAT32_POS, "sat mac");
		clr(32'h0000_0043);
		io(1'b1, fxd_pkg::REG_MODE, 32'h0000_7000);
		{y, v, ay} = {16'hC000, 80'h0};
		fir(1'b1, 1);
		racc(0, 40'h00_8000_0000, "legacy sub");
		clr(32'h0000_0040);
		c.coef_ext = 1'b1;
		io(1'b1, fxd_pkg::REG_CMD, c);
		clr(32'h0000_0010);
		io(1'b1, fxd_pkg::REG_IMASK, 32'h0000_0000);
		c = '0;
		c.opcode = fxd_pkg::OPC_EXP;
		io(1'b1, fxd_pkg::REG_CMD, c);
		rd(fxd_pkg::REG_ISTAT, 32'h0000_0040, "masked istat");
		chk("irq masked", 40'(irq), 40'h00);
		io(1'b1, fxd_pkg::REG_IMASK, 32'h0000_0040);
		rd(fxd_pkg::REG_MODE, 32'h0000_7000, "mode");
		chk("irq unmasked", 40'(irq), 40'h01);
		clr(32'h0000_0040);
		rd(fxd_pkg::REG_ISTAT, 32'h0000_0000, "cleared");
		chk("irq cleared", 40'(irq), 40'h00);
		report_and_stop();
	end
endmodule : fxd_core_bench
